// ---- rtl/rsq_map.svh ----
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH
`define RSQ_CLK_MHZ        125
`define RSQ_STARTUP_MS     15
`define RSQ_SLOT_MS        2
`define RSQ_WINDOW_MS      16
`define RSQ_PGOOD_MS       8
`define RSQ_FAULT_MS       200
`define RSQ_RELEASE_MS     32
`define RSQ_SOFT_US        500
`define RSQ_SLOW_US        8
`define RSQ_FAST_US        4
`define RSQ_CYC_PER_US     `RSQ_CLK_MHZ
`define RSQ_CYC_PER_MS     (`RSQ_CLK_MHZ * 1000)
`define RSQ_CORE_RST       7'h00
`define RSQ_CTRL_RST       4'h3
`define RSQ_CTRL_R2_BIT    0
`define RSQ_CTRL_R3_BIT    1
`define RSQ_CTRL_AUTO_BIT  2
`define RSQ_CTRL_SPEED_BIT 3
`define RSQ_SLOT_CORE      3'h3
`define RSQ_SLOT_R2        3'h2
`define RSQ_SLOT_R3        3'h1
`define RSQ_UP_MAX         7'h08
`define RSQ_DN_MAX         7'h04
`endif

// ---- rtl/rsq_pkg.sv ----
package rsq_pkg;
    typedef enum logic [2:0] {
        RSQ_OFF     = 3'h0,
        RSQ_WAIT    = 3'h1,
        RSQ_SLOTS   = 3'h3,
        RSQ_PGOOD   = 3'h2,
        RSQ_HOLD    = 3'h6,
        RSQ_ACTIVE  = 3'h7,
        RSQ_FAULT   = 3'h5,
        RSQ_STOPPED = 3'h4
    } rsq_state_t;

    typedef struct packed {
        logic [3:0] ctrl;
        logic [6:0] core_code;
    } rsq_regs_t;

    typedef struct packed {
        logic sleep;
        logic shutdown;
        logic reset;
    } rsq_cmd_t;

    typedef struct packed {
        logic       core_on;
        logic       r2_on;
        logic       r3_on;
        logic [1:0] limit_step;
    } rsq_reg_out_t;
endpackage

// ---- rtl/rsq_ramp.sv ----
`timescale 1ns/10ps
`include "rsq_map.svh"
module rsq_ramp #(
    parameter int SLOW_CYC = `RSQ_SLOW_US * `RSQ_CYC_PER_US,
    parameter int FAST_CYC = `RSQ_FAST_US * `RSQ_CYC_PER_US
) (
    // Clock and control.
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    input  wire logic       clear,
    // Settings.
    input  wire logic       auto_ramp,
    input  wire logic       fast,
    input  wire logic [6:0] target,
    // Applied code.
    output logic [6:0]      applied
);
    logic [9:0] tick_cnt;
    logic       tick;
    logic [6:0] diff;
    logic [6:0] next_step;

    // Compare with >= so that a switch to the fast rate does not wait for the counter to wrap.
    assign tick = (tick_cnt >= 10'(fast ? FAST_CYC - 1 : SLOW_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (srst || clear) begin
            tick_cnt <= 10'h000;
        end else if (clk_en) begin
            tick_cnt <= tick ? 10'h000 : tick_cnt + 10'h001;
        end
    end

    always_comb begin
        diff = (target > applied) ? target - applied : applied - target;
        if (target > applied) begin
            // Up steps shrink by powers of two near the target.
            if (diff >= `RSQ_UP_MAX) next_step = `RSQ_UP_MAX;
            else if (diff >= 7'h04) next_step = 7'h04;
            else if (diff >= 7'h02) next_step = 7'h02;
            else next_step = 7'h01;
        end else begin
            // Down steps are four codes, then single codes.
            next_step = (diff >= `RSQ_DN_MAX) ? `RSQ_DN_MAX : 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || clear) begin
            applied <= `RSQ_CORE_RST;
        end else if (clk_en) begin
            if (!auto_ramp) begin
                applied <= target;
            end else if (tick && target != applied) begin
                applied <= (target > applied) ? applied + next_step : applied - next_step;
            end
        end
    end

    a_ramp_up_step : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !clear && auto_ramp && target > applied) |=> (applied - $past(applied) <= 7'h08))
        else $error("ramp up step too large");
    a_ramp_dn_step : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !clear && auto_ramp && target < applied) |=> ($past(applied) - applied <= 7'h04))
        else $error("ramp down step too large");
    a_ramp_direct : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !clear && !auto_ramp) |=> (applied == $past(target)))
        else $error("direct code not applied");
endmodule

// ---- rtl/rsq_top.sv ----
`timescale 1ns/10ps
`include "rsq_map.svh"
// Functional notes
// - Enable rising runs power-up with defaults; enable low keeps the device disabled.
// - After last regulator is good, wait 32 ms then release reset output.
// - Regulators two and three follow their own control bits while enabled.
// - Sleep command turns off only the core regulator.
// - Shutdown command turns all three regulators off together.
// - Restart after sleep or shutdown by enable re-toggle or reset command.
// - Enable low returns every register bit to its default.
// - Enable low refuses all register access.
// - After supply passes threshold, wait about 15 ms before slot counting.
// - Each regulator starts at its slot on 2 ms steps within 16 ms.
// - Wait 8 ms for power good, else fault, all off, wait 200 ms.
// - After fault wait, restart sequence; repeat while fault persists.
// - Soft start only on enable rising while supply is above threshold.
// - Core soft start is a linear ramp of about 500 us.
// - Regulators two and three step current limit 180, 300, 720 mA.
// - Ramp auto bit zero applies a new core code immediately.
// - Ramp auto bit one steps every 8 us slow or 4 us fast.
// - Ramp up adds at most 8 codes, shrinking to 4, 2, 1 near target.
// - Ramp down subtracts at most 4 codes, single near target.
// - Supply lockout forces reset state; recovery reruns power-up.
// - Overheat forces reset state; cooling reruns power-up.
// - Reset output driven low while any monitored voltage is low.
// - Core voltage register holds a 7-bit code of 4 mV steps.
module rsq_top
    import rsq_pkg::*;
#(
    parameter int STARTUP_CYC = `RSQ_STARTUP_MS * `RSQ_CYC_PER_MS,
    parameter int SLOT_CYC    = `RSQ_SLOT_MS * `RSQ_CYC_PER_MS,
    parameter int PGOOD_CYC   = `RSQ_PGOOD_MS * `RSQ_CYC_PER_MS,
    parameter int FAULT_CYC   = `RSQ_FAULT_MS * `RSQ_CYC_PER_MS,
    parameter int RELEASE_CYC = `RSQ_RELEASE_MS * `RSQ_CYC_PER_MS,
    parameter int SOFT_CYC    = `RSQ_SOFT_US * `RSQ_CYC_PER_US,
    parameter int NUM_SLOTS   = `RSQ_WINDOW_MS / `RSQ_SLOT_MS
) (
    // Clock, reset and clock enable.
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             clk_en,
    // Pins and monitors.
    input  wire logic             enable_pin,
    input  wire logic             supply_low_lockout,
    input  wire logic             overheat_cutoff,
    input  wire logic [2:0]       pgood,
    // Register writes and commands from the serial interface.
    input  wire logic             regulator_control_reg_we,
    input  wire logic [3:0]       regulator_control_reg_wdata,
    input  wire logic             core_voltage_reg_we,
    input  wire logic [6:0]       core_voltage_reg_wdata,
    input  rsq_pkg::rsq_cmd_t     cmd,
    // Status and register readback.
    output logic                  serial_enabled,
    output rsq_pkg::rsq_regs_t    regs,
    output rsq_pkg::rsq_state_t   state_out,
    // Regulator controls.
    output rsq_pkg::rsq_reg_out_t reg_out,
    output logic [6:0]            core_code_applied,
    output logic                  soft_start,
    // Open-drain reset output.
    output logic                  reset_out,
    output logic                  reset_out_oe
);
    rsq_state_t state;
    logic [27:0] timer;
    logic [2:0]  slot;
    logic        en_q;
    logic        en_rise;
    logic        fault_hold;
    logic        restart;
    logic        soft_arm;
    logic [15:0] soft_cnt;
    logic [6:0]  soft_code;
    logic        core_on;
    logic        r2_on;
    logic        r3_on;
    logic [1:0]  limit_step;
    logic [6:0]  ramp_code;
    logic [15:0] lim_cnt;
    logic        seq_clear;

    assign en_rise    = enable_pin && !en_q;
    assign fault_hold = supply_low_lockout || overheat_cutoff;
    assign restart    = en_rise || (cmd.reset && enable_pin);
    assign seq_clear  = !enable_pin || fault_hold;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            en_q <= 1'b0;
        end else if (clk_en) begin
            en_q <= enable_pin;
        end
    end

    // Register set; enable low clears all programmed bits and blocks writes.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regs.ctrl      <= `RSQ_CTRL_RST;
            regs.core_code <= `RSQ_CORE_RST;
        end else if (clk_en) begin
            if (!enable_pin || restart) begin
                regs.ctrl      <= `RSQ_CTRL_RST;
                regs.core_code <= `RSQ_CORE_RST;
            end else begin
                if (regulator_control_reg_we) regs.ctrl <= regulator_control_reg_wdata;
                if (core_voltage_reg_we) regs.core_code <= core_voltage_reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial_enabled <= 1'b0;
        end else if (clk_en) begin
            serial_enabled <= enable_pin;
        end
    end

    // Sequencer state machine.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= RSQ_OFF;
            timer <= 28'h0000000;
            slot  <= 3'h0;
        end else if (clk_en) begin
            if (!enable_pin) begin
                state <= RSQ_OFF;
                timer <= 28'h0000000;
            end else if (fault_hold) begin
                state <= RSQ_OFF;
                timer <= 28'h0000000;
            end else if (cmd.shutdown && state != RSQ_OFF) begin
                state <= RSQ_STOPPED;
            end else if (restart) begin
                state <= RSQ_WAIT;
                timer <= 28'h0000000;
            end else begin
                case (state)
                    RSQ_OFF: begin
                        state <= RSQ_WAIT;
                        timer <= 28'h0000000;
                    end
                    RSQ_WAIT: begin
                        if (timer == 28'(STARTUP_CYC - 1)) begin
                            state <= RSQ_SLOTS;
                            timer <= 28'h0000000;
                            slot  <= 3'h0;
                        end else begin
                            timer <= timer + 28'h0000001;
                        end
                    end
                    RSQ_SLOTS: begin
                        if (timer == 28'(SLOT_CYC - 1)) begin
                            timer <= 28'h0000000;
                            slot  <= slot + 3'h1;
                            if (slot == `RSQ_SLOT_CORE || slot == 3'(NUM_SLOTS - 1)) state <= RSQ_PGOOD;
                        end else begin
                            timer <= timer + 28'h0000001;
                        end
                    end
                    RSQ_PGOOD: begin
                        if (&pgood) begin
                            state <= RSQ_HOLD;
                            timer <= 28'h0000000;
                        end else if (timer == 28'(PGOOD_CYC - 1)) begin
                            state <= RSQ_FAULT;
                            timer <= 28'h0000000;
                        end else begin
                            timer <= timer + 28'h0000001;
                        end
                    end
                    RSQ_HOLD: begin
                        if (!(&pgood)) begin
                            timer <= 28'h0000000;
                        end else if (timer == 28'(RELEASE_CYC - 1)) begin
                            state <= RSQ_ACTIVE;
                        end else begin
                            timer <= timer + 28'h0000001;
                        end
                    end
                    RSQ_ACTIVE: begin
                        if (!(&pgood)) begin
                            state <= RSQ_HOLD;
                            timer <= 28'h0000000;
                        end
                    end
                    RSQ_FAULT: begin
                        if (timer == 28'(FAULT_CYC - 1)) begin
                            state <= RSQ_SLOTS;
                            timer <= 28'h0000000;
                            slot  <= 3'h0;
                        end else begin
                            timer <= timer + 28'h0000001;
                        end
                    end
                    RSQ_STOPPED: state <= RSQ_STOPPED;
                    default: state <= RSQ_OFF;
                endcase
            end
        end
    end

    // Soft start is armed only by an enable edge with the supply good.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            soft_arm <= 1'b0;
        end else if (clk_en) begin
            if (seq_clear) begin
                soft_arm <= 1'b0;
            end else if (en_rise && !supply_low_lockout) begin
                soft_arm <= 1'b1;
            end else if (cmd.reset) begin
                soft_arm <= 1'b0;
            end
        end
    end

    // Regulator enables.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            core_on <= 1'b0;
            r2_on   <= 1'b0;
            r3_on   <= 1'b0;
        end else if (clk_en) begin
            if (seq_clear || state == RSQ_FAULT || state == RSQ_STOPPED || state == RSQ_OFF ||
                state == RSQ_WAIT) begin
                core_on <= 1'b0;
                r2_on   <= 1'b0;
                r3_on   <= 1'b0;
            end else begin
                if (cmd.sleep) begin
                    core_on <= 1'b0;
                end else if (state == RSQ_SLOTS && slot == `RSQ_SLOT_CORE && timer == 28'h0000000) begin
                    core_on <= 1'b1;
                end
                if (state == RSQ_SLOTS && slot == `RSQ_SLOT_R2 && timer == 28'h0000000) begin
                    r2_on <= regs.ctrl[`RSQ_CTRL_R2_BIT];
                end else if (state == RSQ_HOLD || state == RSQ_ACTIVE) begin
                    r2_on <= regs.ctrl[`RSQ_CTRL_R2_BIT];
                end
                if (state == RSQ_SLOTS && slot == `RSQ_SLOT_R3 && timer == 28'h0000000) begin
                    r3_on <= regs.ctrl[`RSQ_CTRL_R3_BIT];
                end else if (state == RSQ_HOLD || state == RSQ_ACTIVE) begin
                    r3_on <= regs.ctrl[`RSQ_CTRL_R3_BIT];
                end
            end
        end
    end

    // Core soft-start ramp from zero to the set code over a fixed time.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            soft_cnt <= 16'h0000;
        end else if (clk_en) begin
            if (!core_on || !soft_arm) begin
                soft_cnt <= 16'h0000;
            end else if (soft_cnt != 16'(SOFT_CYC)) begin
                soft_cnt <= soft_cnt + 16'h0001;
            end
        end
    end

    always_comb begin
        soft_code = 7'((32'(ramp_code) * 32'(soft_cnt)) / 32'(SOFT_CYC));
    end

    // Current-limit steps for regulators two and three during start.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lim_cnt    <= 16'h0000;
            limit_step <= 2'h0;
        end else if (clk_en) begin
            if (!(r2_on || r3_on) || !soft_arm) begin
                lim_cnt    <= 16'h0000;
                limit_step <= 2'h0;
            end else if (limit_step != 2'h2) begin
                if (lim_cnt == 16'(SOFT_CYC / 3)) begin
                    lim_cnt    <= 16'h0000;
                    limit_step <= limit_step + 2'h1;
                end else begin
                    lim_cnt <= lim_cnt + 16'h0001;
                end
            end
        end
    end

    rsq_ramp u_ramp (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .clear     (seq_clear),
        .auto_ramp (regs.ctrl[`RSQ_CTRL_AUTO_BIT]),
        .fast      (regs.ctrl[`RSQ_CTRL_SPEED_BIT]),
        .target    (regs.core_code),
        .applied   (ramp_code)
    );

    // Registered outputs.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_out           <= '0;
            core_code_applied <= 7'h00;
            soft_start        <= 1'b0;
            reset_out         <= 1'b0;
            reset_out_oe      <= 1'b1;
            state_out         <= RSQ_OFF;
        end else if (clk_en) begin
            reg_out.core_on    <= core_on;
            reg_out.r2_on      <= r2_on;
            reg_out.r3_on      <= r3_on;
            reg_out.limit_step <= limit_step;
            soft_start         <= soft_arm && core_on && soft_cnt != 16'(SOFT_CYC);
            core_code_applied  <= (soft_arm && soft_cnt != 16'(SOFT_CYC)) ? soft_code : ramp_code;
            reset_out          <= 1'b0;
            reset_out_oe       <= !(state == RSQ_ACTIVE && &pgood && !fault_hold);
            state_out          <= state;
        end
    end

    a_fault_all_off : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && state == RSQ_FAULT) |=> (!core_on && !r2_on && !r3_on))
        else $error("regulator on during fault");
    a_release_late : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && $rose(state == RSQ_ACTIVE)) |-> ($past(state) == RSQ_HOLD))
        else $error("release without hold");
    a_rst_low_pg : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !(&pgood)) |=> reset_out_oe)
        else $error("reset released while power not good");
    a_regs_cleared : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !enable_pin) |=> (regs.ctrl == `RSQ_CTRL_RST && regs.core_code == `RSQ_CORE_RST))
        else $error("registers not cleared");
    a_disabled_off : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !enable_pin) |=> (state == RSQ_OFF && !core_on))
        else $error("device active with enable low");
    a_shutdown_off : assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && enable_pin && !fault_hold && cmd.shutdown && state != RSQ_OFF) |=> ##1 (!core_on && !r2_on && !r3_on))
        else $error("shutdown left a regulator on");
endmodule

// ---- verification/rsq_plant.sv ----
`timescale 1ns/10ps
module rsq_plant
    import rsq_pkg::*;
(
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // Regulator controls and an overload on the core output.
    input  rsq_pkg::rsq_reg_out_t reg_out,
    input  wire logic             fault,
    // Power-good flags, low while a regulator is off.
    output logic [2:0]            pgood
);
    logic [2:0] rise_1;
    logic [2:0] rise_2;

    // Each output comes good three cycles after it is switched on; an overloaded core never does.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rise_1 <= 3'h0;
            rise_2 <= 3'h0;
            pgood  <= 3'h0;
        end else begin
            rise_1 <= {reg_out.r3_on, reg_out.r2_on, reg_out.core_on & ~fault};
            rise_2 <= rise_1 & {reg_out.r3_on, reg_out.r2_on, reg_out.core_on};
            pgood  <= rise_2 & {reg_out.r3_on, reg_out.r2_on, reg_out.core_on};
        end
    end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`include "rsq_map.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %s", $time, m); end end
`define WAITFOR(c, n) for (int k = 0; k < (n) && ((c) !== 1'b1); k++) @(posedge sys_clk) #1;
module tb_top;
    import rsq_pkg::*;
    localparam int ST = 20, SL = 10, PG = 20, FL = 40, RL = 30;
    localparam int SLOW = `RSQ_SLOW_US * `RSQ_CYC_PER_US;
    localparam int FAST = `RSQ_FAST_US * `RSQ_CYC_PER_US;
    logic          sys_clk, srst, enable_pin, supply_low_lockout, overheat_cutoff, fault;
    logic          regulator_control_reg_we, core_voltage_reg_we, serial_enabled;
    logic          soft_start, reset_out, reset_out_oe, soft_seen, lim_mid, clk_en;
    logic [3:0]    regulator_control_reg_wdata;
    logic [6:0]    core_voltage_reg_wdata, core_code_applied;
    logic [2:0]    pgood;
    rsq_cmd_t      cmd;
    rsq_regs_t     regs;
    rsq_state_t    state_out;
    rsq_reg_out_t  reg_out;
    int            error_cnt = 0, checked = 0, cyc = 0;

    rsq_top #(.STARTUP_CYC(ST), .SLOT_CYC(SL), .PGOOD_CYC(PG), .FAULT_CYC(FL), .RELEASE_CYC(RL), .SOFT_CYC(30)) DUT (
        .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .enable_pin(enable_pin),
        .supply_low_lockout(supply_low_lockout), .overheat_cutoff(overheat_cutoff), .pgood(pgood),
        .regulator_control_reg_we(regulator_control_reg_we), .regulator_control_reg_wdata(regulator_control_reg_wdata),
        .core_voltage_reg_we(core_voltage_reg_we), .core_voltage_reg_wdata(core_voltage_reg_wdata), .cmd(cmd),
        .serial_enabled(serial_enabled), .regs(regs), .state_out(state_out), .reg_out(reg_out),
        .core_code_applied(core_code_applied), .soft_start(soft_start), .reset_out(reset_out),
        .reset_out_oe(reset_out_oe));
    rsq_plant plant (.sys_clk(sys_clk), .srst(srst), .reg_out(reg_out), .fault(fault), .pgood(pgood));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task print_verdict;
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (soft_start === 1'b1) soft_seen <= 1'b1;
        if (reg_out.limit_step === 2'h1) lim_mid <= 1'b1;
        if (cyc == 60000) begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            print_verdict;
        end
    end

    task wr_ctrl(input logic [3:0] v);
        @(posedge sys_clk) regulator_control_reg_we <= 1'b1;
        regulator_control_reg_wdata <= v;
        @(posedge sys_clk) regulator_control_reg_we <= 1'b0;
    endtask

    task wr_core(input logic [6:0] v);
        @(posedge sys_clk) core_voltage_reg_we <= 1'b1;
        core_voltage_reg_wdata <= v;
        @(posedge sys_clk) core_voltage_reg_we <= 1'b0;
    endtask

    task send_cmd(input rsq_cmd_t c);
        @(posedge sys_clk) cmd <= c;
        @(posedge sys_clk) cmd <= 3'h0;
    endtask

    // Restart by enable rise or by the reset command, then time the startup delay, the r2 and core slots and the release delay.
    task automatic powerup(input bit by_cmd);
        int t;
        @(posedge sys_clk) soft_seen <= 1'b0;
        lim_mid <= 1'b0;
        if (by_cmd) cmd <= 3'h1;
        else enable_pin <= 1'b1;
        t = cyc;
        @(posedge sys_clk) cmd <= 3'h0;
        `WAITFOR(reg_out.r3_on === 1'b0, 5)
        `WAITFOR(reg_out.r3_on === 1'b1, ST + 2 * SL + 10)
        `CHK(cyc - t >= ST + SL && cyc - t <= ST + SL + 4, 1'b1, "startup delay")
        `CHK(regs, 11'h180, "defaults")
        `CHK(reset_out_oe, 1'b1, "reset held")
        t = cyc;
        `WAITFOR(reg_out.r2_on === 1'b1, SL + 5)
        `CHK(cyc - t, SL, "slot r2")
        t = cyc;
        `WAITFOR(reg_out.core_on === 1'b1, SL + 5)
        `CHK(cyc - t, SL, "slot core")
        `WAITFOR(pgood === 3'h7, PG)
        t = cyc;
        `WAITFOR(reset_out_oe === 1'b0, RL + 8 * SL + 10)
        `CHK(cyc - t >= RL && cyc - t <= RL + 8 * SL + 4, 1'b1, "release delay")
        `CHK(state_out, RSQ_ACTIVE, "active")
        `CHK(reset_out, 1'b0, "reset level")
        if (!by_cmd) begin
            `CHK(soft_seen, 1'b1, "soft start")
            `CHK(lim_mid, 1'b1, "limit middle step")
            `CHK(reg_out.limit_step, 2'h2, "limit final")
        end else begin
            `CHK(soft_seen, 1'b0, "command restart soft start")
        end
    endtask

    task automatic ramp_to(input logic [6:0] tgt, input int per);
        logic [6:0] prev, rem, st;
        int         last, n;
        prev = core_code_applied;
        last = -1;
        n = 0;
        wr_core(tgt);
        while (core_code_applied !== tgt && n < 40000) begin
            @(posedge sys_clk) #1 n++;
            if (core_code_applied !== prev) begin
                rem = (tgt > prev) ? tgt - prev : prev - tgt;
                if (tgt > prev) st = rem >= 7'h08 ? 7'h08 : rem >= 7'h04 ? 7'h04 : rem >= 7'h02 ? 7'h02 : 7'h01;
                else st = rem >= 7'h04 ? 7'h04 : 7'h01;
                `CHK(core_code_applied, (tgt > prev) ? prev + st : prev - st, "ramp step")
                if (last >= 0) `CHK(n - last, per, "ramp interval")
                last = n;
                prev = core_code_applied;
            end
        end
        `WAITFOR(1'b0, per + 5)
        `CHK(core_code_applied, tgt, "ramp end")
    endtask

    task t_regs_ramp;
        logic [6:0] codes [2];
        codes = '{7'h7F, 7'h10};
        wr_ctrl(4'h0);
        `WAITFOR(1'b0, 4)
        `CHK({reg_out.core_on, reg_out.r2_on, reg_out.r3_on}, 3'h4, "r2 r3 off")
        wr_ctrl(4'h3);
        `WAITFOR(1'b0, 4)
        `CHK({reg_out.core_on, reg_out.r2_on, reg_out.r3_on}, 3'h7, "r2 r3 on")
        foreach (codes[i]) begin
            wr_core(codes[i]);
            `WAITFOR(1'b0, 3)
            `CHK(core_code_applied, codes[i], "direct code")
            `CHK(regs.core_code, codes[i], "code readback")
        end
        @(posedge sys_clk) clk_en <= 1'b0;
        wr_core(7'h01);
        `WAITFOR(1'b0, 2)
        `CHK(regs.core_code, codes[1], "frozen write")
        @(posedge sys_clk) clk_en <= 1'b1;
        wr_ctrl(4'h7);
        ramp_to(7'h7F, SLOW);
        wr_ctrl(4'hF);
        ramp_to(7'h00, FAST);
    endtask

    task t_stop;
        wr_core(7'h22);
        send_cmd(3'h4);
        `WAITFOR(reg_out.core_on !== 1'b1, 5)
        `CHK({reg_out.core_on, reg_out.r2_on, reg_out.r3_on}, 3'h3, "sleep core only")
        powerup(1'b1);
        wr_core(7'h33);
        send_cmd(3'h2);
        `WAITFOR({reg_out.core_on, reg_out.r2_on, reg_out.r3_on} !== 3'h7, 5)
        `CHK({reg_out.core_on, reg_out.r2_on, reg_out.r3_on}, 3'h0, "shutdown together")
        @(posedge sys_clk) enable_pin <= 1'b0;
        `WAITFOR(1'b0, 3)
        wr_ctrl(4'hC);
        wr_core(7'h55);
        `WAITFOR(1'b0, 3)
        `CHK(regs, 11'h180, "defaults and refusal")
        `CHK(serial_enabled, 1'b0, "serial off")
        `CHK(state_out, RSQ_OFF, "disabled")
        powerup(1'b0);
    endtask

    task automatic t_fault;
        int t;
        @(posedge sys_clk) enable_pin <= 1'b0;
        fault <= 1'b1;
        repeat (3) @(posedge sys_clk);
        enable_pin <= 1'b1;
        for (int h = 0; h < 2; h++) begin
            `WAITFOR(reg_out.core_on === 1'b1, ST + 10 * SL)
            t = cyc;
            `WAITFOR(reg_out.core_on !== 1'b1, PG + 8 * SL + 10)
            `CHK(cyc - t >= PG && cyc - t <= PG + 8 * SL + 4, 1'b1, "power good wait")
            `CHK({reg_out.core_on, reg_out.r2_on, reg_out.r3_on}, 3'h0, "fault all off")
            `CHK(state_out, RSQ_FAULT, "fault state")
            t = cyc;
            `WAITFOR(reg_out.r3_on === 1'b1, FL + 2 * SL + 10)
            `CHK(cyc - t >= FL + SL && cyc - t <= FL + SL + 4, 1'b1, "hiccup restart")
        end
        @(posedge sys_clk) fault <= 1'b0;
        `WAITFOR(state_out === RSQ_ACTIVE, 8 * SL + PG + RL + 20)
        `CHK(state_out, RSQ_ACTIVE, "fault cleared")
    endtask

    task t_lockout;
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk) supply_low_lockout <= (i == 0);
            overheat_cutoff <= (i == 1);
            `WAITFOR(reg_out.core_on !== 1'b1, 5)
            `CHK({reset_out_oe, reg_out.core_on, reg_out.r2_on, reg_out.r3_on}, 4'h8, "forced reset")
            @(posedge sys_clk) supply_low_lockout <= 1'b0;
            overheat_cutoff <= 1'b0;
            soft_seen <= 1'b0;
            `WAITFOR(state_out === RSQ_ACTIVE, ST + 8 * SL + PG + RL + 50)
            `CHK(state_out, RSQ_ACTIVE, "recovered")
            `CHK(soft_seen, 1'b0, "no soft start")
        end
    endtask

    initial begin
        {srst, enable_pin, supply_low_lockout, overheat_cutoff, fault} = 5'h10;
        {regulator_control_reg_we, core_voltage_reg_we, cmd} = 5'h00;
        regulator_control_reg_wdata = 4'h0;
        core_voltage_reg_wdata = 7'h00;
        soft_seen = 1'b0;
        lim_mid = 1'b0;
        clk_en = 1'b1;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        powerup(1'b0);
        t_regs_ramp;
        t_stop;
        t_fault;
        t_lockout;
        print_verdict;
    end
endmodule
